// >>> gpcfg_map.svh
`ifndef GPCFG_MAP_SVH
`define GPCFG_MAP_SVH

// Register indexes; byte address is four times the index
`define GPCFG_IDX_P41    8'h3c
`define GPCFG_IDX_P42    8'h3d
`define GPCFG_IDX_P43    8'h3e
`define GPCFG_IDX_DATA   8'h50
`define GPCFG_IDX_STAT   8'h51
`define GPCFG_IDX_MASK   8'h52

// Control register fields
`define GPCFG_BIT_DIR    0
`define GPCFG_BIT_INV    1
`define GPCFG_BIT_OD     7
`define GPCFG_FLD_LO     2
`define GPCFG_FLD_HI     3

// Reset value and writable bits
`define GPCFG_CTRL_RST   8'h01
`define GPCFG_WMASK_2B   8'h8f
`define GPCFG_WMASK_1B   8'h87

// Status bits
`define GPCFG_ST_IRQ2    0
`define GPCFG_ST_IRQ3    1
`define GPCFG_ST_FLOPPY  2
`define GPCFG_ST_W       3

`endif

// >>> gpcfg_pkg.sv
package gpcfg_pkg;

  // Bus slave states, Gray along idle, read, read done
  typedef enum logic [1:0]
  {
    GPCFG_ST_IDLE = 2'b00,
    GPCFG_ST_RD   = 2'b01,
    GPCFG_ST_RDY  = 2'b11,
    GPCFG_ST_WR   = 2'b10
  } gpcfg_state_t;

  // Two-bit function field codes
  typedef enum logic [1:0]
  {
    GPCFG_FN_GPIO = 2'b00,
    GPCFG_FN_ALT1 = 2'b01,
    GPCFG_FN_ALT2 = 2'b10,
    GPCFG_FN_ALT3 = 2'b11
  } gpcfg_func_t;

endpackage

// >>> gpcfg_sync.sv
module gpcfg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,    // Bus clock
  input  wire logic             hresetn, // Async reset, low
  input  wire logic [WIDTH-1:0] d_in,    // Foreign-domain level
  output logic      [WIDTH-1:0] q_out    // Synchronised level
);
  logic [WIDTH-1:0] meta_reg;

  // Two flip-flops per bit; only the second stage is visible
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          meta_reg[i] <= 1'b0;
          q_out[i]    <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= d_in[i];
          q_out[i]    <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

// >>> gpcfg_pin.sv
module gpcfg_pin (
  input  wire logic hclk,     // Bus clock
  input  wire logic hresetn,  // Async reset, low
  input  wire logic dir_in,   // One makes the pin an input
  input  wire logic invert,   // One inverts the value
  input  wire logic open_dr,  // One selects open-drain
  input  wire logic alt_en,   // Alternate function owns the pin
  input  wire logic alt_val,  // Alternate function value
  input  wire logic gpio_val, // Software data value
  output logic      pin_out,  // Pin output level
  output logic      pin_oe_n  // Low while driving
);
  logic val;

  // Function value passes the polarity stage
  assign val = (alt_en ? alt_val : gpio_val) ^ invert;

  // Driver: open-drain only pulls low, push-pull drives both
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else if (open_dr)
    begin
      pin_out  <= 1'b0;
      pin_oe_n <= dir_in | val;
    end
    else
    begin
      pin_out  <= val;
      pin_oe_n <= dir_in;
    end
  end
endmodule

// >>> gpcfg_top.sv
// Chosen here: the AHB-Lite slave port.
`include "gpcfg_map.svh"

module gpcfg_top (
  input  wire logic        hclk,                // Bus clock, 10 MHz
  input  wire logic        hresetn,             // Standby power-on reset
  input  wire logic        hsel,                // Slave select
  input  wire logic [31:0] haddr,               // Byte address
  input  wire logic [1:0]  htrans,              // Transfer type
  input  wire logic        hwrite,              // Write when high
  input  wire logic [2:0]  hsize,               // Transfer size
  input  wire logic [31:0] hwdata,              // Write data
  input  wire logic        hready,              // Bus ready in
  output logic      [31:0] hrdata,              // Read data
  output logic             hreadyout,           // Slave ready
  output logic             hresp,               // Always OKAY
  input  wire logic        main_supply_por,     // Main power reset, high
  input  wire logic        hard_reset,          // Hard reset, high
  input  wire logic [2:0]  pin_in,              // Pins 4.1..4.3 level
  output logic      [2:0]  pin_out,             // Pin output level
  output logic      [2:0]  pin_oe_n,            // Low while driving
  input  wire logic        drive_density_select_1, // Density source
  input  wire logic        power_management_event, // Event, high
  output logic             floppy_on_parallel_select, // Floppy select
  output logic             dd_write_enable,     // Disable reg writable
  output logic             irq                  // Level interrupt
);
  import gpcfg_pkg::*;

  gpcfg_state_t          state_reg;
  logic [7:0]            p41_reg;
  logic [7:0]            p42_reg;
  logic [7:0]            p43_reg;
  logic [2:0]            data_reg;
  logic [`GPCFG_ST_W-1:0] status_reg;
  logic [`GPCFG_ST_W-1:0] mask_reg;
  logic [`GPCFG_ST_W-1:0] ev_set;
  logic [7:0]            idx_reg;
  logic                  hit_reg;
  logic [4:0]            sync_q;
  logic [2:0]            pin_s;
  logic [2:0]            pin_prev_reg;
  logic [2:0]            pin_edge;
  logic                  field_clear;
  logic                  accept;
  logic                  wr_go;
  logic [7:0]            wr_byte;
  logic [7:0]            rd_mux;
  gpcfg_func_t           fn41;
  gpcfg_func_t           fn43;
  logic [2:0]            dir_eff;
  logic [2:0]            inv_eff;
  logic [2:0]            od_eff;
  logic [2:0]            alt_en;
  logic [2:0]            alt_val;
  logic [2:0]            in_val;

  // Pins and the two outside resets cross into the bus clock
  gpcfg_sync #(
    .WIDTH (5)
  ) gpcfg_sync_inst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    ({hard_reset, main_supply_por, pin_in}),
    .q_out   (sync_q)
  );

  assign pin_s       = sync_q[2:0];
  assign field_clear = sync_q[3] | sync_q[4];
  assign fn41        = gpcfg_func_t'(p41_reg[3:2]);
  assign fn43        = gpcfg_func_t'(p43_reg[3:2]);

  // Bus request is taken when a transfer is valid and the bus ready
  assign accept = hsel & hready & htrans[1];
  assign wr_go  = (state_reg == GPCFG_ST_WR) & hit_reg;
  assign wr_byte = hwdata[7:0];

  // Address phase capture and slave state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= GPCFG_ST_IDLE;
      idx_reg   <= 8'h00;
      hit_reg   <= 1'b0;
      hreadyout <= 1'b1;
    end
    else if (state_reg == GPCFG_ST_RD)
    begin
      state_reg <= GPCFG_ST_RDY;
      hreadyout <= 1'b1;
    end
    else if (accept)
    begin
      idx_reg   <= haddr[9:2];
      hit_reg   <= (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'b00);
      state_reg <= hwrite ? GPCFG_ST_WR : GPCFG_ST_RD;
      hreadyout <= hwrite;
    end
    else
    begin
      state_reg <= GPCFG_ST_IDLE;
      hreadyout <= 1'b1;
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // Register read selection; unmapped reads give zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (!hit_reg)
      rd_mux = 8'h00;
    else if (idx_reg == `GPCFG_IDX_P41)
      rd_mux = p41_reg;
    else if (idx_reg == `GPCFG_IDX_P42)
      rd_mux = p42_reg;
    else if (idx_reg == `GPCFG_IDX_P43)
      rd_mux = p43_reg;
    else if (idx_reg == `GPCFG_IDX_DATA)
      rd_mux = {5'h00, in_val};
    else if (idx_reg == `GPCFG_IDX_STAT)
      rd_mux = {5'h00, status_reg};
    else if (idx_reg == `GPCFG_IDX_MASK)
      rd_mux = {5'h00, mask_reg};
  end

  // Read data loads during the wait cycle and stands afterwards
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (state_reg == GPCFG_ST_RD)
      hrdata <= {24'h000000, rd_mux};
  end

  // Pin 4.1 control, reserved bits masked off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      p41_reg <= `GPCFG_CTRL_RST;
    else if (wr_go && idx_reg == `GPCFG_IDX_P41)
      p41_reg <= wr_byte & `GPCFG_WMASK_2B;
  end

  // Pin 4.2 control, single function bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      p42_reg <= `GPCFG_CTRL_RST;
    else if (wr_go && idx_reg == `GPCFG_IDX_P42)
      p42_reg <= wr_byte & `GPCFG_WMASK_1B;
  end

  // Pin 4.3 control; code 01 locks the field until a reset clears it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      p43_reg <= `GPCFG_CTRL_RST;
    else
    begin
      if (wr_go && idx_reg == `GPCFG_IDX_P43)
      begin
        p43_reg[7] <= wr_byte[7];
        p43_reg[1:0] <= wr_byte[1:0];
        if (fn43 != GPCFG_FN_ALT1)
          p43_reg[3:2] <= wr_byte[3:2];
      end
      if (field_clear)
        p43_reg[3:2] <= 2'b00;
    end
  end

  // Software output data for the three pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      data_reg <= 3'h0;
    else if (wr_go && idx_reg == `GPCFG_IDX_DATA)
      data_reg <= wr_byte[2:0];
  end

  // Interrupt mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_reg <= '0;
    else if (wr_go && idx_reg == `GPCFG_IDX_MASK)
      mask_reg <= wr_byte[`GPCFG_ST_W-1:0];
  end

  // Either-edge detection on the synchronised pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_prev_reg <= 3'h0;
    else
      pin_prev_reg <= pin_s;
  end

  assign pin_edge = pin_s ^ pin_prev_reg;

  // Edge events per function
  always_comb
  begin
    ev_set = '0;
    ev_set[`GPCFG_ST_IRQ2] = (fn41 == GPCFG_FN_ALT2) & pin_edge[0];
    ev_set[`GPCFG_ST_IRQ3] = (fn43 == GPCFG_FN_ALT3) & pin_edge[2];
    ev_set[`GPCFG_ST_FLOPPY] = (fn43 == GPCFG_FN_ALT2) & pin_edge[2];
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= '0;
    else if (wr_go && idx_reg == `GPCFG_IDX_STAT)
      status_reg <= (status_reg & ~wr_byte[`GPCFG_ST_W-1:0]) | ev_set;
    else
      status_reg <= status_reg | ev_set;
  end

  // Interrupt level from unmasked status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  // Effective direction, polarity and driver per pin
  always_comb
  begin
    dir_eff = {p43_reg[0], p42_reg[0], p41_reg[0]};
    inv_eff = {p43_reg[1], p42_reg[1], p41_reg[1]};
    od_eff  = {p43_reg[7], p42_reg[7], p41_reg[7]};
    if (fn43 == GPCFG_FN_ALT1)
    begin
      dir_eff[2] = 1'b1;
      inv_eff[2] = 1'b0;
    end
    if (fn43 == GPCFG_FN_ALT2)
      dir_eff[2] = 1'b1;
  end

  // Alternate output sources; code 11 on pin 4.1 stays gpio
  always_comb
  begin
    alt_en  = 3'h0;
    alt_val = 3'h0;
    alt_en[0]  = (fn41 == GPCFG_FN_ALT1);
    alt_val[0] = drive_density_select_1;
    alt_en[1]  = p42_reg[2];
    alt_val[1] = ~power_management_event;
  end

  assign in_val = pin_s ^ inv_eff;

  // Pin drivers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      gpcfg_pin gpcfg_pin_inst (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .dir_in   (dir_eff[gi]),
        .invert   (inv_eff[gi]),
        .open_dr  (od_eff[gi]),
        .alt_en   (alt_en[gi]),
        .alt_val  (alt_val[gi]),
        .gpio_val (data_reg[gi]),
        .pin_out  (pin_out[gi]),
        .pin_oe_n (pin_oe_n[gi])
      );
    end
  endgenerate

  // Floppy select follows the pin through the polarity bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      floppy_on_parallel_select <= 1'b0;
    else
      floppy_on_parallel_select <= (fn43 == GPCFG_FN_ALT2) & in_val[2];
  end

  // Device disable register writable unless the lock pin is high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dd_write_enable <= 1'b1;
    else if (fn43 == GPCFG_FN_ALT1)
      dd_write_enable <= ~pin_s[2];
    else
      dd_write_enable <= 1'b1;
  end

  // Checks
  chk_dir_input: assert property (@(posedge hclk) disable iff (!hresetn)
    p41_reg[0] |=> pin_oe_n[0])
    else $error("input pin is driven");

  chk_pol_gpio: assert property (@(posedge hclk) disable iff (!hresetn)
    (p42_reg[2:0] == 3'b010 && !p42_reg[7])
    |=> (pin_out[1] == !$past(data_reg[1])) && !pin_oe_n[1])
    else $error("inverted gpio output wrong");

  chk_od_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    p41_reg[7] |=> (pin_oe_n[0] || !pin_out[0]))
    else $error("open drain drove high");

  chk_dds_route: assert property (@(posedge hclk) disable iff (!hresetn)
    (p41_reg[3:0] == 4'b0100 && !p41_reg[7])
    |=> pin_out[0] == $past(drive_density_select_1))
    else $error("density output not routed");

  chk_event_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (p42_reg[2:0] == 3'b100 && power_management_event)
    |=> !pin_oe_n[1] && !pin_out[1])
    else $error("power event not driven low");

  chk_irq3_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (fn43 == GPCFG_FN_ALT3 && pin_edge[2])
    |=> status_reg[`GPCFG_ST_IRQ3])
    else $error("irq3 edge lost");

  chk_fpp_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (fn43 == GPCFG_FN_ALT2 && pin_edge[2])
    |=> status_reg[`GPCFG_ST_FLOPPY])
    else $error("floppy edge lost");

  chk_wp_force: assert property (@(posedge hclk) disable iff (!hresetn)
    (fn43 == GPCFG_FN_ALT1) |=> pin_oe_n[2])
    else $error("locked pin drove output");

  chk_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (fn43 == GPCFG_FN_ALT1 && !field_clear) |=> fn43 == GPCFG_FN_ALT1)
    else $error("locked field changed");

  chk_lock_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    field_clear |=> p43_reg[3:2] == 2'b00)
    else $error("field not cleared by reset");

  chk_dd_ro: assert property (@(posedge hclk) disable iff (!hresetn)
    (fn43 == GPCFG_FN_ALT1 && pin_s[2]) |=> !dd_write_enable)
    else $error("disable reg writable while pin high");

  chk_dd_rw: assert property (@(posedge hclk) disable iff (!hresetn)
    (fn43 == GPCFG_FN_ALT1 && !pin_s[2]) |=> dd_write_enable)
    else $error("disable reg locked while pin low");

  chk_rsv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    p42_reg[6:3] == 4'h0 && p41_reg[6:4] == 3'h0
    && p43_reg[6:4] == 3'h0)
    else $error("reserved bits set");
endmodule

// >>> gpcfg_board.sv
module gpcfg_board (
  input  wire logic [2:0] pin_out,  // Device output level
  input  wire logic [2:0] pin_oe_n, // Low while the device drives
  input  wire logic [2:0] ext_val,  // Board level when released
  output logic      [2:0] pin_in    // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;

  // Device wins where it drives, else the board level stands
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      pin_in[i] = pin_oe_n[i] ? ext_val[i] : pin_out[i];
  end
endmodule

// >>> gpio_group4_pin_config_tb.sv
`include "gpcfg_map.svh"

module gpio_group4_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] A41  = `GPCFG_IDX_P41;
  localparam logic [7:0] A42  = `GPCFG_IDX_P42;
  localparam logic [7:0] A43  = `GPCFG_IDX_P43;
  localparam logic [7:0] ADAT = `GPCFG_IDX_DATA;
  localparam logic [7:0] AST  = `GPCFG_IDX_STAT;
  localparam logic [7:0] AMSK = `GPCFG_IDX_MASK;

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        main_supply_por, hard_reset, dens, pm_ev, floppy, dd_we, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pin_in, pin_out, pin_oe_n, ext_val;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          bad_count, n_compared, cycles;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  gpcfg_top gpcfg_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .main_supply_por(main_supply_por),
    .hard_reset(hard_reset), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .drive_density_select_1(dens),
    .power_management_event(pm_ev), .floppy_on_parallel_select(floppy),
    .dd_write_enable(dd_we), .irq(irq)
  );

  gpcfg_board gpcfg_board_inst (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
    .pin_in(pin_in)
  );

  // Bus clock, 100 ns period
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Cuts a hang short
  always @(posedge hclk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t timeout", $time);
      end_sim;
    end
  end

  task end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
    end
  endtask

  // Ready and data are taken from the settled value before the edge
  task wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (r !== 1'b1)
    begin
      @(negedge hclk);
      r = hready;
      d = hrdata;
      @(posedge hclk);
    end
  endtask

  // One single word transfer: address phase, then data phase
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] v);
    bus(1'b1, idx, v);
  endtask

  task rchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    cmp_reg(rd, exp);
  endtask

  // Lets n edges pass, then stops where outputs are settled
  task wt(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  task pins(input logic [2:0] v);
    @(posedge hclk) ext_val <= v;
  endtask

  // Main sequence
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; main_supply_por = 1'b0;
    hard_reset = 1'b0; dens = 1'b0; pm_ev = 1'b0; ext_val = 3'h0;
    bad_count = 0; n_compared = 0; cycles = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, reserved bits, unmapped place
    rchk(A41, 32'h01);
    rchk(A42, 32'h01);
    rchk(A43, 32'h01);
    wt(0);
    cmp_reg({29'h0, pin_oe_n}, 32'h7);
    wr(A41, 32'hff);
    rchk(A41, 32'h8f);
    wr(A42, 32'hff);
    rchk(A42, 32'h87);
    rchk(8'h40, 32'h0);
    cmp_bit(hresp, 1'b0);
    wr(A42, 32'h01);
    // Direction, polarity and driver type on pin 4.1
    wr(ADAT, 32'h1);
    wr(A41, 32'h00);
    wt(2);
    cmp_bit(pin_out[0], 1'b1);
    cmp_bit(pin_oe_n[0], 1'b0);
    wr(A41, 32'h02);
    wt(2);
    cmp_bit(pin_out[0], 1'b0);
    wr(A41, 32'h80);
    wt(2);
    cmp_bit(pin_oe_n[0], 1'b1);
    wr(ADAT, 32'h0);
    wt(2);
    cmp_bit(pin_oe_n[0], 1'b0);
    cmp_bit(pin_out[0], 1'b0);
    wr(ADAT, 32'h1);
    wr(A41, 32'h0c);
    wt(2);
    cmp_bit(pin_out[0], 1'b1);
    wr(A41, 32'h01);
    pins(3'h1);
    wt(5);
    rchk(ADAT, 32'h1);
    wr(A41, 32'h03);
    rchk(ADAT, 32'h0);
    // Density output and edge interrupt 2 on pin 4.1
    wr(A41, 32'h04);
    @(posedge hclk) dens <= 1'b1;
    wt(2);
    cmp_bit(pin_out[0], 1'b1);
    @(posedge hclk) dens <= 1'b0;
    wt(2);
    cmp_bit(pin_out[0], 1'b0);
    wr(A41, 32'h09);
    wt(5);
    wr(AST, 32'h7);
    pins(3'h0);
    wt(6);
    rchk(AST, 32'h1);
    wt(0);
    cmp_bit(irq, 1'b0);
    wr(AMSK, 32'h1);
    wt(2);
    cmp_bit(irq, 1'b1);
    wr(AST, 32'h1);
    wt(2);
    cmp_bit(irq, 1'b0);
    rchk(AST, 32'h0);
    // Power event output on pin 4.2, active low
    wr(A42, 32'h04);
    @(posedge hclk) pm_ev <= 1'b1;
    wt(2);
    cmp_bit(pin_out[1], 1'b0);
    cmp_bit(pin_oe_n[1], 1'b0);
    @(posedge hclk) pm_ev <= 1'b0;
    wt(2);
    cmp_bit(pin_out[1], 1'b1);
    // Inverted gpio output on pin 4.2, data bit 1 is zero
    wr(A42, 32'h02);
    wt(2);
    cmp_bit(pin_out[1], 1'b1);
    cmp_bit(pin_oe_n[1], 1'b0);
    wr(A42, 32'h84);
    wt(2);
    cmp_bit(pin_oe_n[1], 1'b1);
    // Edge interrupt 3 on pin 4.3, both edges
    wr(A43, 32'h0d);
    wt(5);
    wr(AST, 32'h7);
    wr(AMSK, 32'h2);
    pins(3'h4);
    wt(6);
    rchk(AST, 32'h2);
    wr(AST, 32'h2);
    pins(3'h0);
    wt(6);
    rchk(AST, 32'h2);
    wt(0);
    cmp_bit(irq, 1'b1);
    // Floppy select follows pin and polarity, either edge flagged
    wr(AMSK, 32'h4);
    wr(A43, 32'h09);
    wt(5);
    wr(AST, 32'h7);
    pins(3'h4);
    wt(6);
    cmp_bit(floppy, 1'b1);
    rchk(AST, 32'h4);
    wr(AST, 32'h4);
    pins(3'h0);
    wt(6);
    cmp_bit(floppy, 1'b0);
    rchk(AST, 32'h4);
    wr(A43, 32'h0b);
    wt(3);
    cmp_bit(floppy, 1'b1);
    wr(AST, 32'h7);
    // Write protect control on pin 4.3 and its lock
    wr(A43, 32'h06);
    pins(3'h4);
    wt(5);
    cmp_bit(pin_oe_n[2], 1'b1);
    cmp_bit(dd_we, 1'b0);
    rchk(ADAT, 32'h4);
    pins(3'h0);
    wt(5);
    cmp_bit(dd_we, 1'b1);
    wr(A43, 32'h00);
    rchk(A43, 32'h04);
    wr(A43, 32'h0b);
    rchk(A43, 32'h07);
    // Hard reset and main supply reset release the lock
    @(posedge hclk) hard_reset <= 1'b1;
    wt(4);
    @(posedge hclk) hard_reset <= 1'b0;
    rchk(A43, 32'h03);
    wr(A43, 32'h04);
    @(posedge hclk) main_supply_por <= 1'b1;
    wt(4);
    @(posedge hclk) main_supply_por <= 1'b0;
    rchk(A43, 32'h00);
    // Standby reset in mid-run reloads all control registers
    wr(A43, 32'h04);
    @(posedge hclk) hresetn <= 1'b0;
    wt(3);
    @(posedge hclk) hresetn <= 1'b1;
    rchk(A41, 32'h01);
    rchk(A42, 32'h01);
    rchk(A43, 32'h01);
    end_sim;
  end
endmodule
